/* rtl/pattern_read_path.sv */
// One beat per core_clk cycle: the double-rate serialiser sits outside.
module pattern_read_path
	import pattern_read_pkg::*;
#(
	parameter bit REPLICATE_BIT0 = 1'b1,
	parameter int LINE_DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire cmd_t cmd,
	input wire logic [DQ_W-1:0] array_beat_data,
	output logic array_beat_req,
	output logic [2:0] array_beat_idx,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe,
	output logic dqs_out,
	output logic dll_enable,
	output logic pattern_mode,
	output logic latency_unsupported,
	output logic cmd_refused
);

	// ************************************************************
	// Command decode
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BURST = 2'b10
	} burst_state_t;

	function automatic logic [LAT_W-1:0] field_lat(input logic [2:0] code,
			input logic [LAT_W-1:0] base);
		field_lat = LAT_W'(code) + base;
	endfunction : field_lat

	function automatic logic is_cmd(input cmd_t c, input logic ras,
			input logic cas, input logic we);
		is_cmd = !c.cs_n && c.ras_n == ras && c.cas_n == cas && c.we_n == we;
	endfunction : is_cmd

	wire logic cmd_read = is_cmd(cmd, 1'b1, 1'b0, 1'b1);
	wire logic cmd_mrs = is_cmd(cmd, 1'b0, 1'b0, 1'b0);
	wire logic cmd_nop = is_cmd(cmd, 1'b1, 1'b1, 1'b1);
	wire logic cmd_other = !cmd.cs_n && !cmd_read && !cmd_mrs && !cmd_nop;

	logic [ADDR_W-1:0] mr0_q;
	logic [ADDR_W-1:0] mr1_q;
	logic [ADDR_W-1:0] mr2_q;
	logic [ADDR_W-1:0] mr3_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			mr0_q <= '0;
			mr1_q <= '0;
			mr2_q <= '0;
			mr3_q <= '0;
		end else if (cmd_mrs) begin
			case (cmd.ba)
				MR0_SEL: mr0_q <= cmd.addr;
				MR1_SEL: mr1_q <= cmd.addr;
				MR2_SEL: mr2_q <= cmd.addr;
				MR3_SEL: mr3_q <= cmd.addr;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Latency and mode
	// ************************************************************
	wire logic dll_off = mr1_q[MR1_DLL_OFF_BIT];
	wire logic [1:0] bl_mode = mr0_q[MR0_BL_LSB +: 2];
	wire logic [LAT_W-1:0] cl = field_lat(mr0_q[MR0_CL_LSB +: 3], CL_BASE);
	wire logic [LAT_W-1:0] cwl = field_lat(mr2_q[MR2_CWL_LSB +: 3], CWL_BASE);
	wire logic [1:0] al_code = mr1_q[MR1_AL_LSB +: 2];
	wire logic [LAT_W-1:0] al = (al_code == AL_CL_M1) ? cl - 5'h01 :
		(al_code == AL_CL_M2) ? cl - 5'h02 : 5'h00;
	// Loop off: strobe referenced one cycle early
	wire logic [LAT_W-1:0] rl = al + cl - (dll_off ? 5'h01 : 5'h00);
	// Pattern and array reads share one latency line
	wire logic [LAT_W-1:0] line_lat = rl - 5'h01;

	assign dll_enable = !dll_off;
	assign pattern_mode = mr3_q[MR3_PATTERN_EN_BIT];
	assign latency_unsupported = dll_off &&
		(cl != DLL_OFF_CL || cwl != DLL_OFF_CWL);
	// Only reads, mode sets and no-operations are legal while patterns are served
	assign cmd_refused = pattern_mode && cmd_other;

	// Only A12 and A2 steer a read; the rest is dropped
	wire logic chop_sel = (bl_mode == BL_FIXED4) ||
		(bl_mode == BL_OTF && !cmd.addr[ADDR_CHOP_BIT]);
	launch_t launch_in;
	assign launch_in.pattern = pattern_mode;
	assign launch_in.chop = chop_sel;
	assign launch_in.upper_half = cmd.addr[ADDR_HALF_BIT];
	assign launch_in.loc = mr3_q[MR3_LOC_LSB +: 2];

	logic launch_valid;
	launch_t launch;

	read_latency_line #(
		.DEPTH(LINE_DEPTH),
		.W(LAUNCH_W)
	) u_line (
		.core_clk(core_clk),
		.srst(srst),
		.in_valid(cmd_read),
		.in_data(launch_in),
		.lat(line_lat),
		.out_valid(launch_valid),
		.out_data(launch)
	);

	// ************************************************************
	// Burst engine
	// ************************************************************
	burst_state_t state_q;
	burst_state_t state_d;
	logic [2:0] beat_q;
	logic [2:0] beat_d;
	logic [2:0] last_q;
	logic [2:0] last_d;
	logic pat_q;
	logic pat_d;
	logic [1:0] loc_q;
	logic [1:0] loc_d;
	logic [DQ_W-1:0] dq_d;

	wire logic beat_run = (state_q == ST_BURST) && beat_q != last_q;
	// A new launch restarts the engine, even mid-burst
	wire logic beat_load = launch_valid || beat_run;

	always_comb begin
		state_d = state_q;
		beat_d = beat_q;
		last_d = last_q;
		pat_d = pat_q;
		loc_d = loc_q;
		case (state_q)
			ST_IDLE, ST_BURST: begin
				if (launch_valid) begin
					state_d = ST_BURST;
					pat_d = launch.pattern;
					loc_d = launch.loc;
					beat_d = (launch.chop && launch.upper_half) ?
						HALF_OFFSET : 3'h0;
					last_d = launch.chop ?
						beat_d + LAST_BEAT4 : LAST_BEAT8;
				end else if (beat_run) begin
					beat_d = beat_q + 3'h1;
				end else begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// Reserved locations read zero; the controller must not rely on it
	wire logic [7:0] loc_pattern = (loc_d == LOC_CALIBRATION) ?
		CAL_PATTERN : 8'h00;
	wire logic pat_bit = loc_pattern[beat_d];
	wire logic [7:0] lane = {{7{REPLICATE_BIT0 & pat_bit}}, pat_bit};

	assign array_beat_req = beat_load && !pat_d;
	assign array_beat_idx = beat_d;
	assign dq_d = pat_d ? {lane, lane} : array_beat_data;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			beat_q <= 3'h0;
			last_q <= 3'h0;
			pat_q <= 1'b0;
			loc_q <= 2'h0;
			dq_out <= '0;
			dq_oe <= 1'b0;
			dqs_out <= 1'b0;
		end else begin
			state_q <= state_d;
			beat_q <= beat_d;
			last_q <= last_d;
			pat_q <= pat_d;
			loc_q <= loc_d;
			dq_out <= beat_load ? dq_d : '0;
			dq_oe <= beat_load;
			dqs_out <= beat_load && !beat_d[0];
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_pattern_lane_bit0: assert property (
		dq_oe && pat_q |-> dq_out[0] == dq_out[8])
		else $error("pattern bit differs between byte lanes");
	a_pattern_upper_bits: assert property (
		dq_oe && pat_q |->
		dq_out[7:1] == (REPLICATE_BIT0 ? {7{dq_out[0]}} : 7'h00))
		else $error("pattern upper bits neither copy nor zero");
	// Checked at beat 6 so a relaunch cannot hide inside the window
	a_pattern_sequence: assert property (
		launch_valid && launch.pattern && !launch.chop &&
		launch.loc == LOC_CALIBRATION ##1 !launch_valid[*7] |->
		$past(dq_out[0], 6) == 1'b0 && $past(dq_out[0], 5) == 1'b1 &&
		$past(dq_out[0], 4) == 1'b0 && $past(dq_out[0], 3) == 1'b1 &&
		$past(dq_out[0], 2) == 1'b0 && $past(dq_out[0], 1) == 1'b1 &&
		dq_out[0] == 1'b0 ##1 dq_out[0] == 1'b1)
		else $error("calibration sequence out of order");
	a_chop_half: assert property (
		launch_valid && launch.chop |=>
		beat_q == ($past(launch.upper_half) ? HALF_OFFSET : 3'h0))
		else $error("chopped burst started on wrong half");
	a_read_latency: assert property (
		cmd_read && !dll_off && al == 5'h00 && cl == 5'h06 |->
		##6 dq_oe)
		else $error("read data not at read latency");
	a_dll_off_early: assert property (
		cmd_read && dll_off && al == 5'h00 && cl == 5'h06 |->
		##5 dq_oe)
		else $error("loop-off read not one cycle early");
	a_deselect_keeps: assert property (
		cmd.cs_n |=> $stable(mr3_q) && $stable(mr1_q))
		else $error("mode changed under deselect");
	a_burst_length: assert property (
		launch_valid && !launch.chop ##1 !launch_valid[*7] |->
		dq_oe ##1 dq_oe)
		else $error("eight-beat burst cut short");
	a_chop_length: assert property (
		launch_valid && launch.chop ##1 !launch_valid[*4] |=> !dq_oe)
		else $error("chopped burst ran past four beats");
	a_nop_idle: assert property (
		cmd_nop |-> !cmd_refused ##1 $stable(mr0_q) && $stable(mr3_q))
		else $error("no-operation refused or acted on");
	a_dll_unsupported: assert property (
		dll_off && (cl == 5'h07 || cwl == 5'h05) |->
		latency_unsupported)
		else $error("unsupported loop-off latency not flagged");
	a_refuse_other: assert property (
		pattern_mode && !cmd.cs_n && !cmd.ras_n && cmd.cas_n |->
		cmd_refused)
		else $error("command accepted in pattern mode");

	c_pattern_bl8: cover property (launch_valid && launch.pattern
		&& !launch.chop);
	c_pattern_upper: cover property (launch_valid && launch.pattern
		&& launch.chop && launch.upper_half);
	c_dll_off_read: cover property (cmd_read && dll_off);
	c_back_to_back: cover property (launch_valid && beat_run);

endmodule : pattern_read_path

/* shared/pattern_read_pkg.sv */
package pattern_read_pkg;

	// ************************************************************
	// Command and mode register layout
	// ************************************************************
	localparam int ADDR_W = 14;
	localparam int BA_W = 3;
	localparam int DQ_W = 16;
	localparam int LAT_W = 5;

	localparam logic [BA_W-1:0] MR0_SEL = 3'h0;
	localparam logic [BA_W-1:0] MR1_SEL = 3'h1;
	localparam logic [BA_W-1:0] MR2_SEL = 3'h2;
	localparam logic [BA_W-1:0] MR3_SEL = 3'h3;

	// MR0 fields
	localparam int MR0_BL_LSB = 0;
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam int MR0_CL_LSB = 4;
	localparam logic [LAT_W-1:0] CL_BASE = 5'h04;
	// MR1 fields
	localparam int MR1_DLL_OFF_BIT = 0;
	localparam int MR1_AL_LSB = 3;
	localparam logic [1:0] AL_ZERO = 2'h0;
	localparam logic [1:0] AL_CL_M1 = 2'h1;
	localparam logic [1:0] AL_CL_M2 = 2'h2;
	// MR2 fields
	localparam int MR2_CWL_LSB = 3;
	localparam logic [LAT_W-1:0] CWL_BASE = 5'h05;
	// MR3 fields
	localparam int MR3_PATTERN_EN_BIT = 2;
	localparam int MR3_LOC_LSB = 0;
	localparam logic [1:0] LOC_CALIBRATION = 2'h0;

	// Read address bits that still matter in pattern mode
	localparam int ADDR_HALF_BIT = 2;
	localparam int ADDR_CHOP_BIT = 12;

	// Only latencies the loop-disabled mode must support
	localparam logic [LAT_W-1:0] DLL_OFF_CL = 5'h06;
	localparam logic [LAT_W-1:0] DLL_OFF_CWL = 5'h06;

	// Calibration sequence, beat 0 in the LSB
	localparam logic [7:0] CAL_PATTERN = 8'haa;
	localparam logic [2:0] LAST_BEAT8 = 3'h7;
	localparam logic [2:0] LAST_BEAT4 = 3'h3;
	localparam logic [2:0] HALF_OFFSET = 3'h4;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BA_W-1:0] ba;
		logic [ADDR_W-1:0] addr;
	} cmd_t;

	typedef struct packed {
		logic pattern;
		logic chop;
		logic upper_half;
		logic [1:0] loc;
	} launch_t;

	localparam int LAUNCH_W = $bits(launch_t);

endpackage : pattern_read_pkg

/* rtl/read_latency_line.sv */
// Fixed-depth delay line with a selectable tap; output is registered, so
// the total delay from in_valid to out_valid is exactly lat cycles for lat of two or more.
module read_latency_line
	import pattern_read_pkg::*;
#(
	parameter int DEPTH = 32,
	parameter int W = LAUNCH_W
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	input wire logic [LAT_W-1:0] lat,
	output logic out_valid,
	output logic [W-1:0] out_data
);

	logic [DEPTH-1:0] vld_q;
	logic [W-1:0] dat_q [DEPTH];
	logic [LAT_W-1:0] tap;

	// Latencies below two are never programmed; clamp keeps the index legal
	assign tap = (lat < 5'h02) ? 5'h00 : lat - 5'h02;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			vld_q <= '0;
			out_valid <= 1'b0;
		end else begin
			vld_q <= {vld_q[DEPTH-2:0], in_valid};
			out_valid <= vld_q[tap];
		end
	end

	always_ff @(posedge core_clk) begin
		dat_q[0] <= in_data;
		for (int i = 1; i < DEPTH; i++) begin
			dat_q[i] <= dat_q[i-1];
		end
		out_data <= dat_q[tap];
	end

endmodule : read_latency_line

/* sim/host_ctrl_model.sv */
module host_ctrl_model
	import pattern_read_pkg::*;
(
	input wire logic core_clk,
	input wire logic array_beat_req,
	input wire logic [2:0] array_beat_idx,
	input wire logic cmd_refused,
	output cmd_t cmd,
	output logic [DQ_W-1:0] array_beat_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Command driver and array model
	// ************************************************************
	localparam cmd_t DESEL = {1'b1, 3'b000, 3'h5, 14'h3fff};
	localparam cmd_t NOP = {1'b0, 3'b111, 3'h2, 14'h1555};
	logic tgl = 1'b0;
	logic refused_seen = 1'b0;
	logic [DQ_W-1:0] beat;

	initial cmd = DESEL;
	// Off-request data inverted so a stale read cannot pass
	assign beat = {8'ha5, 5'h00, array_beat_idx};
	assign array_beat_data = array_beat_req ? beat : ~beat;

	// Deselect carries an MRS-like code on purpose
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge core_clk);
			tgl = ~tgl;
			cmd <= tgl ? NOP : DESEL;
		end
	endtask : idle

	// No self-refresh: clock enable and termination stay static
	task automatic send(input logic [2:0] rcw, input logic [2:0] ba,
		input logic [13:0] a);
		@(posedge core_clk);
		cmd <= {1'b0, rcw, ba, a};
		@(negedge core_clk);
		refused_seen = cmd_refused;
	endtask : send

	task automatic mrs(input logic [2:0] sel, input logic [13:0] v);
		send(3'b000, sel, v);
	endtask : mrs

	// Column bits 1:0 forced low on every read
	task automatic rd(input logic [2:0] ba, input logic [13:0] a);
		send(3'b101, ba, {a[13:2], 2'b00});
	endtask : rd
endmodule : host_ctrl_model

/* sim/pattern_read_path_bench.sv */
module pattern_read_path_bench
	import pattern_read_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [13:0] m0, m1, m2, m3;
		logic [2:0] ba;
		logic [13:0] a;
		int rl, nb, st;
		bit pat;
	} row_t;

	// Pattern rows keep the loop locked and CL=6 CWL=6
	row_t rows[8] = '{
		'{14'h20, 14'h0, 14'h8, 14'h0, 3'h0, 14'h0, 6, 8, 0, 1'b0},
		'{14'h20, 14'h0, 14'h8, 14'h4, 3'h0, 14'h0, 6, 8, 0, 1'b1},
		'{14'h22, 14'h0, 14'h8, 14'h4, 3'h0, 14'h0, 6, 4, 0, 1'b1},
		'{14'h22, 14'h0, 14'h8, 14'h4, 3'h0, 14'h4, 6, 4, 4, 1'b1},
		'{14'h21, 14'h0, 14'h8, 14'h4, 3'h7, 14'h2bf8, 6, 4, 0, 1'b1},
		'{14'h21, 14'h0, 14'h8, 14'h4, 3'h0, 14'h1000, 6, 8, 0, 1'b1},
		'{14'h20, 14'h1, 14'h8, 14'h0, 3'h0, 14'h0, 5, 8, 0, 1'b0},
		'{14'h20, 14'h8, 14'h8, 14'h0, 3'h0, 14'h0, 11, 8, 0, 1'b0}};

	logic core_clk = 1'b0;
	logic srst = 1'b1;
	cmd_t cmd;
	logic [DQ_W-1:0] array_beat_data, dq_out;
	logic [2:0] array_beat_idx;
	logic array_beat_req, dq_oe, dqs_out, dll_enable, pattern_mode;
	logic latency_unsupported, cmd_refused;
	int n_errors = 0;
	int checks_done = 0;

	// One steady slow clock, never changed with the loop off
	initial forever #2.5 core_clk = ~core_clk;

	pattern_read_path u_dut (.core_clk, .srst, .cmd, .array_beat_data,
		.array_beat_req, .array_beat_idx, .dq_out, .dq_oe, .dqs_out,
		.dll_enable, .pattern_mode, .latency_unsupported, .cmd_refused);

	host_ctrl_model u_host (.core_clk, .array_beat_req, .array_beat_idx,
		.cmd_refused, .cmd, .array_beat_data);

	// ************************************************************
	// Checking and reporting
	// ************************************************************
	task automatic chk(input string nm, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic run_row(input int i);
		row_t r;
		logic [15:0] e;
		r = rows[i];
		u_host.mrs(MR0_SEL, r.m0);
		u_host.mrs(MR1_SEL, r.m1);
		u_host.mrs(MR2_SEL, r.m2);
		u_host.mrs(MR3_SEL, r.m3);
		u_host.idle(1);
		@(negedge core_clk);
		chk("dll_enable", {15'h0, ~r.m1[0]}, {15'h0, dll_enable});
		chk("pattern_mode", {15'h0, r.m3[2]}, {15'h0, pattern_mode});
		chk("lat_unsup", 16'h0, {15'h0, latency_unsupported});
		u_host.rd(r.ba, r.a);
		chk("refused", 16'h0, {15'h0, u_host.refused_seen});
		u_host.idle(r.rl - 1);
		@(negedge core_clk);
		chk("early_oe", 16'h0, {15'h0, dq_oe});
		for (int k = 0; k < r.nb; k++) begin
			u_host.idle(1);
			@(negedge core_clk);
			e = r.pat ? {16{CAL_PATTERN[r.st + k]}} :
				{8'ha5, 5'h00, 3'(r.st + k)};
			chk("dq_out", e, dq_out);
			chk("dq_oe", 16'h1, {15'h0, dq_oe});
			chk("dqs_out", {15'h0, k % 2 == 0}, {15'h0, dqs_out});
		end
		u_host.idle(1);
		@(negedge core_clk);
		chk("burst_end", 16'h0, {15'h0, dq_oe});
		$display("row %0d done", i);
	endtask : run_row

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
		chk("rst_dll", 16'h1, {15'h0, dll_enable});
		chk("rst_pat", 16'h0, {15'h0, pattern_mode});
		chk("rst_oe", 16'h0, {15'h0, dq_oe});
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			run_row(i);
		end
		u_host.mrs(MR3_SEL, 14'h4);
		u_host.send(3'b011, 3'h0, 14'h0);
		chk("refuse_act", 16'h1, {15'h0, u_host.refused_seen});
		u_host.send(3'b111, 3'h0, 14'h0);
		chk("refuse_nop", 16'h0, {15'h0, u_host.refused_seen});
		u_host.mrs(MR3_SEL, 14'h0);
		u_host.mrs(MR1_SEL, 14'h1);
		u_host.mrs(MR2_SEL, 14'h0);
		u_host.idle(1);
		@(negedge core_clk);
		chk("cwl5_off", 16'h1, {15'h0, latency_unsupported});
		$display("refusal and latency test done");
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
		chk("rerst_dll", 16'h1, {15'h0, dll_enable});
		chk("rerst_lat", 16'h0, {15'h0, latency_unsupported});
		$display("second reset test done");
		give_verdict();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		give_verdict();
	end
endmodule : pattern_read_path_bench
